// *** pcpl_top.sv ***
// control-pin logic: button, sleep request, host reset, interrupt pin, AHB-Lite registers
//
// The placing of the registers and the AHB-Lite interface to the registers are this design's own decisions.
`timescale 1ns/1ps
`include "pcpl_consts.svh"
module pcpl_top #(
  parameter int CYC_PER_US = `PCPL_CLK_HZ / `PCPL_HZ_PER_MHZ,
  parameter int US_PER_MS  = `PCPL_US_PER_MS
) (
  input  wire logic        CLK,
  input  wire logic        RST_N,
  input  wire logic        HSEL,
  input  wire logic [31:0] HADDR,
  input  wire logic [1:0]  HTRANS,
  input  wire logic        HWRITE,
  input  wire logic [2:0]  HSIZE,
  input  wire logic [31:0] HWDATA,
  input  wire logic        HREADY,
  output logic             HREADYOUT,
  output logic [31:0]      HRDATA,
  output logic             HRESP,
  input  wire logic        POWER_BUTTON_IN,
  input  wire logic        SLEEP_REQ_IN,
  input  wire logic        COMPANION_IRQ_IN,
  input  wire logic        BUTTON_MODE_FUSE,
  input  wire logic [1:0]  BUTTON_DEBOUNCE_DEFAULT,
  input  wire logic [1:0]  LONG_PRESS_TIME_DEFAULT,
  input  wire logic [7:0]  HOST_RESET_RELEASE_SLOT,
  input  wire logic        HOST_RESET_OUT_N_I,
  output logic             HOST_RESET_OUT_N_O,
  output logic             HOST_RESET_OUT_N_OE,
  input  wire logic        IRQ_OUT_N_I,
  output logic             IRQ_OUT_N_O,
  output logic             IRQ_OUT_N_OE
);
  localparam int NF = `PCPL_NFLAG;
  localparam int NH = `PCPL_NHOLD;

  // ---------------- timebase and input synchronisers
  pcpl_tick_if tk ();
  pcpl_timebase #(
    .CYC_PER_US (CYC_PER_US),
    .US_PER_MS  (US_PER_MS)
  ) u_tb (
    .clk   (CLK),
    .rst_n (RST_N),
    .tk    (tk)
  );

  logic [`PCPL_SYNC_W-1:0] sync_q;
  pcpl_sync #(
    .W       (`PCPL_SYNC_W),
    .RST_VAL (`PCPL_SYNC_RST)
  ) u_sync (
    .clk   (CLK),
    .rst_n (RST_N),
    .d_in  ({IRQ_OUT_N_I, HOST_RESET_OUT_N_I, COMPANION_IRQ_IN, SLEEP_REQ_IN, POWER_BUTTON_IN}), // R23
    .q     (sync_q)
  );
  logic btn_s;
  logic sleep_s;
  logic comp_s;
  logic hrst_pin_s;
  logic irq_pin_s;
  assign btn_s      = sync_q[0];
  assign sleep_s    = sync_q[1];
  assign comp_s     = sync_q[2];
  assign hrst_pin_s = sync_q[3];
  assign irq_pin_s  = sync_q[4];

  // ---------------- configuration
  logic       mode_r;
  logic [1:0] dbnc_sel_r;
  logic [1:0] lp_sel_r;
  logic       lprst_en_r;
  logic       sinv_r;
  logic [7:0] rel_slot_r;
  logic       reload_r;
  logic       wr_ctrl;
  logic       wr_flag;
  logic       wr_mask;
  logic [7:0] wr_addr_r;
  logic       wr_pend_r;

  // fuses are static straps; caught during reset and on a long-press restart
  always_ff @(posedge CLK) begin
    if (!RST_N || reload_r) begin
      mode_r     <= BUTTON_MODE_FUSE;        // R1 R2
      dbnc_sel_r <= BUTTON_DEBOUNCE_DEFAULT; // R5
      lp_sel_r   <= LONG_PRESS_TIME_DEFAULT; // R12
      rel_slot_r <= HOST_RESET_RELEASE_SLOT;
      lprst_en_r <= 1'b0;
      sinv_r     <= 1'b0;
    end else if (wr_ctrl) begin
      dbnc_sel_r <= HWDATA[`PCPL_CTRL_DBNC_LSB +: 2];
      lp_sel_r   <= HWDATA[`PCPL_CTRL_TSEL_LSB +: 2];
      lprst_en_r <= HWDATA[`PCPL_CTRL_LPRST_BIT];
      sinv_r     <= HWDATA[`PCPL_CTRL_SINV_BIT];
    end
  end

  // ---------------- button level timing
  pcpl_pkg::pcpl_ms_t lvl_cnt_r;
  logic               btn_prev_r;

  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      btn_prev_r <= 1'b1;
      lvl_cnt_r  <= '0;
    end else begin
      btn_prev_r <= btn_s;
      if (btn_s != btn_prev_r) begin
        lvl_cnt_r <= '0; // R24
      end else if (tk.ms_tick && lvl_cnt_r != 15'h7FFF) begin
        lvl_cnt_r <= lvl_cnt_r + 15'h0001;
      end
    end
  end

  function automatic pcpl_pkg::pcpl_ms_t fall_ms(input logic [1:0] sel);
    unique case (sel)
      2'h2:    fall_ms = 15'(`PCPL_DB_MID_MS);
      2'h3:    fall_ms = 15'(`PCPL_DB_LONG_MS);
      default: fall_ms = 15'(`PCPL_DB_SHORT_MS);
    endcase
  endfunction

  function automatic pcpl_pkg::pcpl_ms_t hold_ms(input int idx);
    unique case (idx)
      0:       hold_ms = 15'(`PCPL_HOLD1_MS);
      1:       hold_ms = 15'(`PCPL_HOLD2_MS);
      2:       hold_ms = 15'(`PCPL_HOLD3_MS);
      3:       hold_ms = 15'(`PCPL_HOLD4_MS);
      default: hold_ms = 15'(`PCPL_HOLD8_MS);
    endcase
  endfunction

  pcpl_pkg::pcpl_ms_t lp_ms;
  assign lp_ms = 15'(`PCPL_LP_BASE_MS) << lp_sel_r; // R11

  // an event fires on the tick after the count is reached, so the hold is strictly longer
  logic          press_evt;
  logic          rel_evt;
  logic          lp_evt;
  logic [NH-1:0] hold_evt;
  assign press_evt = tk.ms_tick && !btn_s && (lvl_cnt_r == fall_ms(dbnc_sel_r)); // R4
  assign rel_evt   = tk.ms_tick && btn_s && (lvl_cnt_r == 15'(`PCPL_DB_SHORT_MS)); // R4
  assign lp_evt    = tk.ms_tick && !btn_s && (lvl_cnt_r == lp_ms);
  for (genvar h = 0; h < NH; h++) begin : g_hold
    assign hold_evt[h] = tk.ms_tick && !btn_s && (lvl_cnt_r == hold_ms(h)); // R8
  end

  // sync stages reset to the push-button idle level; level mode waits until they hold the pin
  logic [2:0] settle_r;
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      settle_r <= 3'h0;
    end else if (settle_r != 3'h7) begin
      settle_r <= settle_r + 3'h1;
    end
  end

  // ---------------- power state machine
  pcpl_pkg::pcpl_state_e state_r;
  logic                  restart_r;
  logic                  rst_rel_r;
  logic [7:0]            slot_cnt_r;
  logic [7:0]            slot_us_r;
  logic [7:0]            wait_cnt_r;
  logic                  sleep_req;
  logic                  sys_on;
  logic                  pwr_on_evt;
  logic                  off_evt;
  logic                  rst_evt;

  assign sleep_req  = sleep_s ^ sinv_r; // R13
  assign sys_on     = (state_r == pcpl_pkg::PCPL_ON) || (state_r == pcpl_pkg::PCPL_STBY);
  assign pwr_on_evt = mode_r ? press_evt : (btn_s && (settle_r == 3'h7)); // R1 R2 R6
  assign rst_evt    = lp_evt && lprst_en_r; // R9
  assign off_evt    = (lp_evt && !lprst_en_r) || (!mode_r && press_evt); // R10 R1

  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      state_r    <= pcpl_pkg::PCPL_OFF;
      restart_r  <= 1'b0;
      rst_rel_r  <= 1'b0;
      slot_cnt_r <= 8'h00;
      slot_us_r  <= 8'h00;
      wait_cnt_r <= 8'h00;
      reload_r   <= 1'b0;
    end else begin
      reload_r <= 1'b0;
      unique case (state_r)
        pcpl_pkg::PCPL_OFF: begin
          rst_rel_r <= 1'b0;
          if (pwr_on_evt) begin
            state_r    <= pcpl_pkg::PCPL_PWRUP;
            slot_cnt_r <= 8'h00;
            slot_us_r  <= 8'h00;
          end
        end
        pcpl_pkg::PCPL_PWRUP: begin
          if (slot_cnt_r == rel_slot_r) begin
            rst_rel_r <= 1'b1; // R14
            state_r   <= sleep_req ? pcpl_pkg::PCPL_STBY : pcpl_pkg::PCPL_ON;
          end else if (tk.us_tick) begin
            if (slot_us_r == 8'(`PCPL_SLOT_US - 1)) begin
              slot_us_r  <= 8'h00;
              slot_cnt_r <= slot_cnt_r + 8'h01;
            end else begin
              slot_us_r <= slot_us_r + 8'h01;
            end
          end
        end
        pcpl_pkg::PCPL_ON,
        pcpl_pkg::PCPL_STBY: begin
          if (rst_evt || off_evt) begin
            state_r    <= pcpl_pkg::PCPL_PWRDN;
            restart_r  <= rst_evt; // R9 R10
            rst_rel_r  <= 1'b0; // R15
            wait_cnt_r <= 8'h00;
          end else begin
            state_r <= sleep_req ? pcpl_pkg::PCPL_STBY : pcpl_pkg::PCPL_ON; // R13
          end
        end
        pcpl_pkg::PCPL_PWRDN: begin
          if (tk.us_tick) begin
            if (wait_cnt_r == 8'(`PCPL_RESTART_US)) begin
              reload_r   <= restart_r; // R9
              state_r    <= restart_r ? pcpl_pkg::PCPL_PWRUP : pcpl_pkg::PCPL_OFF;
              slot_cnt_r <= 8'h00;
              slot_us_r  <= 8'h00;
            end else begin
              wait_cnt_r <= wait_cnt_r + 8'h01;
            end
          end
        end
      endcase
    end
  end

  // ---------------- interrupt flags, mask, self-test
  logic [NF-1:0] flag_r;
  logic [NF-1:0] mask_r;
  logic [NF-1:0] flag_set;
  logic [NF-1:0] flag_clr;
  logic          comp_prev_r;
  logic          test_r;
  logic [7:0]    test_cnt_r;
  logic          irq_oe_r;

  always_comb begin
    flag_set                     = '0;
    flag_set[`PCPL_FLG_PRESS]    = press_evt && sys_on; // R7 R6
    flag_set[`PCPL_FLG_REL]      = rel_evt && sys_on; // R7
    flag_set[`PCPL_FLG_HOLD0 +: NH] = sys_on ? hold_evt : '0; // R8
    flag_set[`PCPL_FLG_COMP]     = comp_prev_r && !comp_s; // R19 R20
  end
  assign flag_clr = wr_flag ? HWDATA[NF-1:0] : '0;

  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      flag_r      <= '0;
      comp_prev_r <= 1'b1;
    end else begin
      comp_prev_r <= comp_s;
      flag_r      <= (flag_r & ~flag_clr) | flag_set; // R17
    end
  end

  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      mask_r <= `PCPL_MASK_RST;
    end else if (wr_mask) begin
      mask_r <= HWDATA[NF-1:0];
    end
  end

  // a second write of 1 during a running pulse does not stretch it
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      test_r     <= 1'b0;
      test_cnt_r <= 8'h00;
    end else if (!test_r) begin
      test_cnt_r <= 8'h00;
      test_r     <= wr_ctrl && HWDATA[`PCPL_CTRL_TEST_BIT]; // R18
    end else if (tk.us_tick) begin
      if (test_cnt_r == 8'(`PCPL_TEST_US)) begin
        test_r <= 1'b0; // R18
      end else begin
        test_cnt_r <= test_cnt_r + 8'h01;
      end
    end
  end

  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      irq_oe_r <= 1'b0;
    end else begin
      irq_oe_r <= (|(flag_r & ~mask_r)) || test_r; // R16 R22 R17
    end
  end

  assign IRQ_OUT_N_O         = 1'b0;
  assign IRQ_OUT_N_OE        = irq_oe_r;
  assign HOST_RESET_OUT_N_O  = 1'b0;
  assign HOST_RESET_OUT_N_OE = !rst_rel_r; // R15

  // ---------------- AHB-Lite slave, zero wait states
  logic        acc;
  logic [31:0] rd_nxt;
  logic [31:0] rdata_r;
  assign acc = HSEL && HTRANS[1] && HREADY;

  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      wr_pend_r <= 1'b0;
      wr_addr_r <= 8'h00;
    end else begin
      wr_pend_r <= acc && HWRITE && (HADDR[31:`PCPL_ADDR_W] == '0);
      wr_addr_r <= HADDR[`PCPL_ADDR_W-1:0];
    end
  end
  assign wr_ctrl = wr_pend_r && (wr_addr_r == `PCPL_ADDR_CTRL);
  assign wr_flag = wr_pend_r && (wr_addr_r == `PCPL_ADDR_FLAG);
  assign wr_mask = wr_pend_r && (wr_addr_r == `PCPL_ADDR_MASK);

  always_comb begin
    rd_nxt = 32'h0000_0000;
    if (HADDR[31:`PCPL_ADDR_W] == '0) begin
      unique case (HADDR[`PCPL_ADDR_W-1:0])
        `PCPL_ADDR_CTRL: begin
          rd_nxt[`PCPL_CTRL_DBNC_LSB +: 2]  = dbnc_sel_r;
          rd_nxt[`PCPL_CTRL_TSEL_LSB +: 2]  = lp_sel_r;
          rd_nxt[`PCPL_CTRL_LPRST_BIT]      = lprst_en_r;
          rd_nxt[`PCPL_CTRL_SINV_BIT]       = sinv_r;
          rd_nxt[`PCPL_CTRL_TEST_BIT]       = test_r;
        end
        `PCPL_ADDR_FLAG: rd_nxt[NF-1:0] = flag_r;
        `PCPL_ADDR_MASK: rd_nxt[NF-1:0] = mask_r;
        `PCPL_ADDR_STAT: begin
          rd_nxt[0]   = !btn_s; // R3
          rd_nxt[1]   = comp_s; // R21
          rd_nxt[2]   = (state_r == pcpl_pkg::PCPL_STBY);
          rd_nxt[3]   = rst_rel_r;
          rd_nxt[4]   = hrst_pin_s;
          rd_nxt[5]   = irq_pin_s;
          rd_nxt[6]   = mode_r;
          rd_nxt[11:7] = state_r;
        end
        default: rd_nxt = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      rdata_r <= 32'h0000_0000;
    end else if (acc && !HWRITE) begin
      rdata_r <= rd_nxt;
    end
  end

  assign HREADYOUT = 1'b1;
  assign HRESP     = 1'b0;
  assign HRDATA    = rdata_r;
endmodule // pcpl_top

// *** pcpl_consts.svh ***
// constants for the control-pin logic: offsets, fields, reset values, timing
// What this block does
// R1: fuse 0: button is a level; low keeps off, high needed to power on.
// R2: fuse 1: button is an edge input from a push button pulling low.
// R3: level sense reads 1 while the button input is low, else 0.
// R4: falling debounce 32/32/125/750 ms by selector; rising always 32 ms.
// R5: debounce selector loads its fuse default after power up.
// R6: press held longer than debounce starts power on with fuse 1 while off, and raises interrupts while on.
// R7: while system on, debounced press and release set their flags.
// R8: hold flags set after 1, 2, 3, 4 and 8 s held low.
// R9: long press with reset enabled: power down, wait 30 us, power up with fuses.
// R10: long press with reset disabled starts a turn off.
// R11: long press time selector gives 2, 4, 8 or 16 s.
// R12: long press selector loads its fuse default after power up.
// R13: standby exactly while sleep input xor polarity invert is 1.
// R14: host reset released in fuse-set power-up slot, needed before system on.
// R15: host reset stays released while on, asserted when power down starts.
// R16: interrupt output driven low while any unmasked flag is set.
// R17: flags clear by writing 1; output released only once cleared.
// R18: self-test bit pulses interrupt output 100 us then clears itself.
// R19: companion interrupt input raises an interrupt event of this device.
// R20: companion falling edge sets its flag, driving output when unmasked.
// R21: companion sense bit mirrors the live companion input level.
// R22: mask bit 0 lets a flag drive the output; 1 blocks it.
// R23: button, sleep and companion inputs are synchronised before any timing.
// R24: intervals counted from a fixed timebase, restarting on level change.
`ifndef PCPL_CONSTS_SVH
`define PCPL_CONSTS_SVH

`define PCPL_ADDR_W         8
`define PCPL_ADDR_CTRL      8'h00
`define PCPL_ADDR_FLAG      8'h04
`define PCPL_ADDR_MASK      8'h08
`define PCPL_ADDR_STAT      8'h0C

`define PCPL_CTRL_DBNC_LSB  0
`define PCPL_CTRL_TSEL_LSB  2
`define PCPL_CTRL_LPRST_BIT 4
`define PCPL_CTRL_SINV_BIT  5
`define PCPL_CTRL_TEST_BIT  6

`define PCPL_NFLAG          8
`define PCPL_FLG_PRESS      0
`define PCPL_FLG_REL        1
`define PCPL_FLG_HOLD0      2
`define PCPL_NHOLD          5
`define PCPL_FLG_COMP       7
`define PCPL_MASK_RST       8'hFF

`define PCPL_CLK_HZ         125000000
`define PCPL_HZ_PER_MHZ     1000000
`define PCPL_US_PER_MS      1000
`define PCPL_DB_SHORT_MS    32
`define PCPL_DB_MID_MS      125
`define PCPL_DB_LONG_MS     750
`define PCPL_HOLD1_MS       1000
`define PCPL_HOLD2_MS       2000
`define PCPL_HOLD3_MS       3000
`define PCPL_HOLD4_MS       4000
`define PCPL_HOLD8_MS       8000
`define PCPL_LP_BASE_MS     2000
`define PCPL_TEST_US        100
`define PCPL_RESTART_US     30
`define PCPL_SLOT_US        1

`define PCPL_SYNC_W         5
`define PCPL_SYNC_RST       5'h1D

`endif

// *** pcpl_pkg.sv ***
// types shared by the control-pin logic
package pcpl_pkg;
  typedef enum logic [4:0] {
    PCPL_OFF   = 5'h01,
    PCPL_PWRUP = 5'h02,
    PCPL_ON    = 5'h04,
    PCPL_STBY  = 5'h08,
    PCPL_PWRDN = 5'h10
  } pcpl_state_e;
  typedef logic [14:0] pcpl_ms_t;
endpackage

// *** pcpl_tick_if.sv ***
// timebase enables carried from the divider to the control logic
`timescale 1ns/1ps
interface pcpl_tick_if;
  logic us_tick;
  logic ms_tick;
  modport src (output us_tick, output ms_tick);
  modport snk (input us_tick, input ms_tick);
endinterface

// *** pcpl_sync.sv ***
// three-stage input synchroniser, output changes once stages two and three agree
`timescale 1ns/1ps
module pcpl_sync #(
  parameter int              W       = 1,
  parameter logic [W-1:0]    RST_VAL = '0
) (
  input  wire logic          clk,
  input  wire logic          rst_n,
  input  wire logic [W-1:0]  d_in,
  output logic      [W-1:0]  q
);
  if (W < 1) begin : g_chk
    $error("pcpl_sync: width must be at least one");
  end
  for (genvar i = 0; i < W; i++) begin : g_bit
    logic s1_r;
    logic s2_r;
    logic s3_r;
    always_ff @(posedge clk) begin
      if (!rst_n) begin
        s1_r <= RST_VAL[i];
        s2_r <= RST_VAL[i];
        s3_r <= RST_VAL[i];
        q[i] <= RST_VAL[i];
      end else begin
        s1_r <= d_in[i];
        s2_r <= s1_r;
        s3_r <= s2_r;
        if (s2_r == s3_r) begin
          q[i] <= s3_r;
        end
      end
    end
  end
endmodule // pcpl_sync

// *** pcpl_timebase.sv ***
// divider producing one-cycle microsecond and millisecond enables
`timescale 1ns/1ps
module pcpl_timebase #(
  parameter int CYC_PER_US = 125,
  parameter int US_PER_MS  = 1000
) (
  input  wire logic  clk,
  input  wire logic  rst_n,
  pcpl_tick_if.src   tk
);
  if (CYC_PER_US < 2 || CYC_PER_US > 65535 || US_PER_MS < 1 || US_PER_MS > 65535) begin : g_chk
    $error("pcpl_timebase: divider values out of range");
  end
  logic [15:0] cyc_r;
  logic [15:0] us_r;
  logic        us_tick_r;
  logic        ms_tick_r;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      cyc_r     <= 16'h0000;
      us_tick_r <= 1'b0;
    end else if (cyc_r == 16'(CYC_PER_US - 1)) begin
      cyc_r     <= 16'h0000;
      us_tick_r <= 1'b1;
    end else begin
      cyc_r     <= cyc_r + 16'h0001;
      us_tick_r <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      us_r      <= 16'h0000;
      ms_tick_r <= 1'b0;
    end else if (cyc_r == 16'(CYC_PER_US - 1)) begin
      ms_tick_r <= (us_r == 16'(US_PER_MS - 1));
      us_r      <= (us_r == 16'(US_PER_MS - 1)) ? 16'h0000 : us_r + 16'h0001;
    end else begin
      ms_tick_r <= 1'b0;
    end
  end

  assign tk.us_tick = us_tick_r;
  assign tk.ms_tick = ms_tick_r;
endmodule // pcpl_timebase

// *** pcpl_top_chk.sv ***
// assertion checker for the control-pin logic top
`timescale 1ns/1ps
module pcpl_top_chk #(
  parameter int CYC_PER_US = 125
) (
  input wire logic        CLK,
  input wire logic        RST_N,
  input wire logic        HSEL,
  input wire logic [31:0] HADDR,
  input wire logic [1:0]  HTRANS,
  input wire logic        HWRITE,
  input wire logic [31:0] HWDATA,
  input wire logic        HREADY,
  input wire logic        HREADYOUT,
  input wire logic        HRESP,
  input wire logic        COMPANION_IRQ_IN,
  input wire logic        HOST_RESET_OUT_N_O,
  input wire logic        HOST_RESET_OUT_N_OE,
  input wire logic        IRQ_OUT_N_O,
  input wire logic        IRQ_OUT_N_OE
);
  // margin past the pulse so a slightly late end is not flagged by the quiet check
  localparam int LOAD = 101 * CYC_PER_US + 8;
  logic       wr_q;
  logic [7:0] wa_q;
  logic [7:0] mask_r;
  int         tst_cnt;
  logic       quiet_q;
  logic       quiet;
  logic       wr_tst;
  logic       wr_clr;
  default clocking @(posedge CLK); endclocking
  default disable iff (!RST_N);
  assign wr_tst = wr_q && HREADY && (wa_q == 8'h00) && HWDATA[6];
  assign wr_clr = wr_q && HREADY && (wa_q == 8'h04) && (HWDATA[7:0] == 8'hFF);
  assign quiet  = (mask_r == 8'hFF) && (tst_cnt == 0);
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      wr_q <= 1'b0;
      wa_q <= 8'h00;
    end else if (HREADY) begin
      wr_q <= HSEL && HTRANS[1] && HWRITE && (HADDR[31:8] == 24'h000000);
      wa_q <= HADDR[7:0];
    end
  end
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      mask_r  <= 8'hFF;
      tst_cnt <= 0;
      quiet_q <= 1'b1;
    end else begin
      if (wr_q && HREADY && (wa_q == 8'h08)) mask_r <= HWDATA[7:0];
      tst_cnt <= wr_tst ? LOAD : ((tst_cnt > 0) ? tst_cnt - 1 : 0);
      quiet_q <= quiet;
    end
  end
  AST_BUS_OKAY: assert property (HREADYOUT && !HRESP) else $error("bus not zero-wait OKAY");
  AST_OD_LOW: assert property (!HOST_RESET_OUT_N_O && !IRQ_OUT_N_O)
    else $error("open-drain pin drives high");
  AST_COMP_IRQ: assert property ($fell(COMPANION_IRQ_IN) && !mask_r[7] |-> ##[2:10] IRQ_OUT_N_OE)
    else $error("companion edge did not assert irq");
  AST_TEST_START: assert property (wr_tst |-> ##[1:4] IRQ_OUT_N_OE [*8])
    else $error("self-test pulse did not start");
  AST_TEST_LEN: assert property ((tst_cnt < LOAD - 4) && (tst_cnt > 2 * CYC_PER_US + 8) |-> IRQ_OUT_N_OE)
    else $error("self-test pulse too short");
  AST_MASK_QUIET: assert property (quiet && quiet_q |-> !IRQ_OUT_N_OE)
    else $error("irq asserted while all masked");
  AST_FLAG_CLR: assert property (wr_clr |-> ##[1:3] !IRQ_OUT_N_OE)
    else $error("irq not released after clear");
  AST_HRST_HOLD: assert property ($rose(HOST_RESET_OUT_N_OE) |=> HOST_RESET_OUT_N_OE [*8])
    else $error("host reset pulse too short");
  AST_HRST_REL: assert property ($fell(HOST_RESET_OUT_N_OE) |-> $past(HOST_RESET_OUT_N_OE, 8))
    else $error("host reset released without slot wait");
  cover property (wr_tst);
  cover property ($fell(HOST_RESET_OUT_N_OE));
  cover property ($fell(COMPANION_IRQ_IN) && !mask_r[7]);
endmodule // pcpl_top_chk
bind pcpl_top pcpl_top_chk #(.CYC_PER_US(CYC_PER_US)) u_chk (.*);

// *** pcpl_partner.sv ***
// far side: push button, standby line, companion irq and pulled-up open-drain pins
`timescale 1ns/1ps
module pcpl_partner (
  input  wire logic press,
  input  wire logic sleep,
  input  wire logic comp_low,
  input  wire logic hrst_oe,
  input  wire logic irq_oe,
  output logic      btn_pin,
  output logic      sleep_pin,
  output logic      comp_pin,
  output logic      hrst_pin,
  output logic      irq_pin
);
  assign btn_pin   = ~press;
  assign sleep_pin = sleep;
  // companion output is open drain, the pull-up holds it high when released
  assign comp_pin  = ~comp_low;
  assign hrst_pin  = ~hrst_oe;
  assign irq_pin   = ~irq_oe;
endmodule // pcpl_partner

// *** pcpl_top_tb.sv ***
// self-checking bench for the control-pin logic
`timescale 1ns/1ps
module pcpl_top_tb;
  // one ms is 8 cycles with the shortened timebase
  localparam int MS = 8;
  logic        CLK, RST_N, HSEL, HWRITE, HREADY, HREADYOUT, HRESP;
  logic [31:0] HADDR, HWDATA, HRDATA, rdv;
  logic [1:0]  HTRANS, BUTTON_DEBOUNCE_DEFAULT, LONG_PRESS_TIME_DEFAULT;
  logic [2:0]  HSIZE;
  logic [7:0]  HOST_RESET_RELEASE_SLOT;
  logic        POWER_BUTTON_IN, SLEEP_REQ_IN, COMPANION_IRQ_IN, BUTTON_MODE_FUSE;
  logic        HOST_RESET_OUT_N_I, HOST_RESET_OUT_N_O, HOST_RESET_OUT_N_OE;
  logic        IRQ_OUT_N_I, IRQ_OUT_N_O, IRQ_OUT_N_OE, press, sleep, comp_low;
  int          err_total, compares;
  assign HREADY = HREADYOUT;
  pcpl_top #(.CYC_PER_US(4), .US_PER_MS(2)) u_dut (.*);
  pcpl_partner u_far (.press(press), .sleep(sleep), .comp_low(comp_low), .hrst_oe(HOST_RESET_OUT_N_OE),
    .irq_oe(IRQ_OUT_N_OE), .btn_pin(POWER_BUTTON_IN), .sleep_pin(SLEEP_REQ_IN), .comp_pin(COMPANION_IRQ_IN),
    .hrst_pin(HOST_RESET_OUT_N_I), .irq_pin(IRQ_OUT_N_I));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      err_total++;
      $display("Error at %0t: saw %h expected %h", $time, got, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge CLK);
  endtask
  task automatic bus(input logic [31:0] a, input logic w, input logic [31:0] d);
    HSEL <= 1'b1;
    HTRANS <= 2'b10;
    HADDR <= a;
    HWRITE <= w;
    @(posedge CLK);
    while (HREADY !== 1'b1) @(posedge CLK);
    HTRANS <= 2'b00;
    HSEL <= 1'b0;
    HWDATA <= d;
    @(posedge CLK);
    while (HREADY !== 1'b1) @(posedge CLK);
    rdv = HRDATA;
  endtask
  task automatic rdc(input logic [31:0] a, input logic [31:0] e, input logic [31:0] m);
    bus(a, 1'b0, 32'h00000000);
    chk(rdv & m, e);
  endtask
  task automatic st(input pcpl_pkg::pcpl_state_e s);
    rdc(32'h0000000C, 32'(s) << 7, 32'h00000F80);
  endtask
  task automatic t_reset;
    rdc(32'h00000000, 32'h00000002, 32'h0000007F);
    rdc(32'h00000004, 32'h00000000, 32'h000000FF);
    rdc(32'h00000008, 32'h000000FF, 32'h000000FF);
    rdc(32'h00000010, 32'h00000000, 32'hFFFFFFFF);
    chk(IRQ_OUT_N_OE, 1'b0);
    st(pcpl_pkg::PCPL_OFF);
  endtask
  task automatic t_power_on;
    press <= 1'b1;
    cyc(100 * MS);
    st(pcpl_pkg::PCPL_OFF);
    rdc(32'h0000000C, 32'h00000001, 32'h00000001);
    cyc(40 * MS);
    st(pcpl_pkg::PCPL_ON);
    chk(HOST_RESET_OUT_N_OE, 1'b0);
    rdc(32'h0000000C, 32'h00000078, 32'h00000078);
    press <= 1'b0;
    cyc(40 * MS);
    rdc(32'h0000000C, 32'h00000000, 32'h00000001);
  endtask
  task automatic t_flags;
    bus(32'h00000008, 1'b1, 32'h00000000);
    bus(32'h00000000, 1'b1, 32'h00000000);
    bus(32'h00000004, 1'b1, 32'h000000FF);
    press <= 1'b1;
    cyc(40 * MS);
    rdc(32'h00000004, 32'h00000001, 32'h000000FF);
    chk(IRQ_OUT_N_OE, 1'b1);
    bus(32'h00000004, 1'b1, 32'h000000FF);
    cyc(3);
    chk(IRQ_OUT_N_OE, 1'b0);
    cyc(1000 * MS);
    rdc(32'h00000004, 32'h00000004, 32'h000000FF);
    cyc(1000 * MS);
    st(pcpl_pkg::PCPL_OFF);
    chk(HOST_RESET_OUT_N_OE, 1'b1);
    press <= 1'b0;
    cyc(40 * MS);
    bus(32'h00000004, 1'b1, 32'h000000FF);
    bus(32'h00000008, 1'b1, 32'h000000FF);
  endtask
  task automatic t_long_reset;
    int i;
    press <= 1'b1;
    cyc(140 * MS);
    press <= 1'b0;
    cyc(40 * MS);
    bus(32'h00000000, 1'b1, 32'h00000010);
    press <= 1'b1;
    for (i = 0; i < 2100 * MS && HOST_RESET_OUT_N_OE !== 1'b1; i++) @(posedge CLK);
    st(pcpl_pkg::PCPL_PWRDN);
    for (i = 0; i < 200 && HOST_RESET_OUT_N_OE !== 1'b0; i++) @(posedge CLK);
    chk(32'(i >= 120), 32'h00000001);
    st(pcpl_pkg::PCPL_ON);
    rdc(32'h00000000, 32'h00000002, 32'h0000007F);
    press <= 1'b0;
    cyc(40 * MS);
  endtask
  task automatic t_sleep;
    int i;
    for (i = 0; i < 4; i++) begin
      bus(32'h00000000, 1'b1, 32'h00000002 | (32'(i[1]) << 5));
      sleep <= i[0];
      cyc(10);
      rdc(32'h0000000C, 32'(i[0] ^ i[1]) << 2, 32'h00000004);
    end
    sleep <= 1'b0;
    bus(32'h00000000, 1'b1, 32'h00000002);
  endtask
  task automatic t_comp;
    bus(32'h00000004, 1'b1, 32'h000000FF);
    comp_low <= 1'b1;
    cyc(10);
    rdc(32'h0000000C, 32'h00000000, 32'h00000002);
    rdc(32'h00000004, 32'h00000080, 32'h000000FF);
    chk(IRQ_OUT_N_OE, 1'b0);
    bus(32'h00000008, 1'b1, 32'h0000007F);
    cyc(3);
    chk(IRQ_OUT_N_OE, 1'b1);
    bus(32'h00000004, 1'b1, 32'h000000FF);
    cyc(3);
    chk(IRQ_OUT_N_OE, 1'b0);
    comp_low <= 1'b0;
    cyc(10);
    comp_low <= 1'b1;
    cyc(12);
    chk(IRQ_OUT_N_OE, 1'b1);
    bus(32'h00000004, 1'b1, 32'h000000FF);
    comp_low <= 1'b0;
    bus(32'h00000008, 1'b1, 32'h000000FF);
  endtask
  task automatic t_selftest;
    bus(32'h00000000, 1'b1, 32'h00000042);
    cyc(5);
    chk(IRQ_OUT_N_OE, 1'b1);
    rdc(32'h00000000, 32'h00000040, 32'h00000040);
    cyc(380);
    chk(IRQ_OUT_N_OE, 1'b1);
    cyc(40);
    chk(IRQ_OUT_N_OE, 1'b0);
    rdc(32'h00000000, 32'h00000000, 32'h00000040);
  endtask
  task automatic t_level;
    RST_N <= 1'b0;
    BUTTON_MODE_FUSE <= 1'b0;
    press <= 1'b1;
    cyc(3);
    RST_N <= 1'b1;
    cyc(100);
    st(pcpl_pkg::PCPL_OFF);
    press <= 1'b0;
    cyc(60);
    st(pcpl_pkg::PCPL_ON);
    chk(HOST_RESET_OUT_N_OE, 1'b0);
  endtask
  task automatic summarize;
    if (err_total == 0 && compares > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  initial begin
    CLK = 1'b0;
    forever #4 CLK = ~CLK;
  end
  initial begin
    RST_N = 1'b0;
    HSEL = 1'b0;
    HTRANS = 2'b00;
    HADDR = 32'h00000000;
    HWRITE = 1'b0;
    HSIZE = 3'b010;
    HWDATA = 32'h00000000;
    BUTTON_MODE_FUSE = 1'b1;
    BUTTON_DEBOUNCE_DEFAULT = 2'b10;
    LONG_PRESS_TIME_DEFAULT = 2'b00;
    HOST_RESET_RELEASE_SLOT = 8'h03;
    press = 1'b0;
    sleep = 1'b0;
    comp_low = 1'b0;
    err_total = 0;
    compares = 0;
    cyc(3);
    RST_N <= 1'b1;
    @(posedge CLK);
    t_reset;
    t_power_on;
    t_flags;
    t_long_reset;
    t_sleep;
    t_comp;
    t_selftest;
    t_level;
    summarize;
  end
  initial begin
    #400000;
    err_total++;
    summarize;
  end
endmodule // pcpl_top_tb
